// ### logic/i2css_defines.svh
// offsets, field positions, reset values and timing counts of the two-wire slave controller
`ifndef I2CSS_DEFINES_SVH
`define I2CSS_DEFINES_SVH

`define I2CSS_OFF_CONFIG      8'h00
`define I2CSS_OFF_OWN_ADDR    8'h04
`define I2CSS_OFF_ENABLE      8'h08
`define I2CSS_OFF_DATA_CMD    8'h0c
`define I2CSS_OFF_RAW_STATUS  8'h10
`define I2CSS_OFF_EVENT_MASK  8'h14
`define I2CSS_OFF_CLR_RD_REQ  8'h18
`define I2CSS_OFF_ABORT_CLEAR 8'h1c
`define I2CSS_OFF_STATUS      8'h20

`define I2CSS_CFG_MASTER_BIT  0
`define I2CSS_CFG_ADDR10_BIT  3
`define I2CSS_CFG_SLVOFF_BIT  6
`define I2CSS_CFG_ULTRA_BIT   7

`define I2CSS_CMD_BIT         8
`define I2CSS_RAW_RXFULL_BIT  2
`define I2CSS_RAW_RDREQ_BIT   5
`define I2CSS_RAW_ABORT_BIT   6

`define I2CSS_ST_TXFULL_BIT   0
`define I2CSS_ST_RXFULL_BIT   1
`define I2CSS_ST_ACTIVE_BIT   2
`define I2CSS_ST_STRETCH_BIT  3
`define I2CSS_ST_SETTLED_BIT  4

`define I2CSS_RST_MASTER      1'b1
`define I2CSS_RST_SLVOFF      1'b1
`define I2CSS_RST_ADDR10      1'b0
`define I2CSS_RST_ULTRA       1'b0
`define I2CSS_RST_OWN_ADDR    10'h055
`define I2CSS_RST_MASK        2'h3

`define I2CSS_HDR10           5'h1e
`define I2CSS_SETTLE_CYC      3'h6

`endif

// ### logic/i2css_pkg.sv
// types shared by the two-wire slave controller
package i2css_pkg;

   typedef enum logic [3:0] {
      S_IDLE,
      S_ADDR,
      S_ADDR_ACK,
      S_ADDR2,
      S_RD_WAIT,
      S_TX_BIT,
      S_TX_ACK,
      S_RX_BIT,
      S_RX_STALL,
      S_RX_ACK
   } i2css_fsm_t;

   typedef struct packed {
      logic ultra;
      logic slave_off;
      logic addr10;
      logic master_role;
   } i2css_cfg_t;

   typedef struct packed {
      logic abort;
      logic rd_req;
   } i2css_evt_t;

   typedef struct packed {
      i2css_cfg_t cfg;
      logic [9:0] own_addr;
      logic       enable;
      i2css_evt_t mask;
      i2css_evt_t raw;
      logic       flush_lock;
      logic       tx_full;
      logic [7:0] tx_data;
      logic       rx_full;
      logic [7:0] rx_data;
      i2css_fsm_t fsm;
      logic [7:0] shreg;
      logic [3:0] cnt;
      logic       rw;
      logic       hit10;
      logic       ack_seen;
      logic       scl_s1;
      logic       scl_s2;
      logic       scl_q;
      logic       sda_s1;
      logic       sda_s2;
      logic       sda_q;
      logic [2:0] settle;
      logic       scl_drv;
      logic       sda_drv;
      logic [31:0] rdata;
   } i2css_state_t;

endpackage

// ### logic/i2css_top.sv
// two-wire bus slave controller with register port and clock stretching
//
// Operation
// R1: scl is only pulled low or released, never driven high
// R2: sample sda on observed scl rise, change own sda only while scl low
// R3: a released clock counts only once scl is seen high
// R4: high phase ends at the first observed fall, restarting low phase
// R5: low phase lasts as long as any party holds scl low
// R6: slave may stretch scl low; bits advance only on observed edges
// R7: software never sets slave enabled together with master role
// R8: own 10-bit address is written while disabled and used for matching
// R9: config bit 3 picks 7-bit or 10-bit slave addressing
// R10: slave-only needs slave-off and master role zero before enable
// R11: configuration survives disable, no reprogramming needed
// R12: synchronisers reset to one; leave reset only when bus idle
// R13: reset with slave off, enable after about six clocks of settling
// R14: acknowledge a matching address, direction bit picks transmit or receive
// R15: on read request set status bit five and stretch until data
// R16: with events masked software polls raw status about every ten periods
// R17: stale transmit data at a read request sets abort bit six, flushed
// R18: transmit stays flushed until the abort clear register is read
// R19: response byte written to data register with command bit 8 zero
// R20: read of a masked flag returning one clears it
// R21: with data present release scl and shift the byte out
// R22: no slave transmit in ultra-fast mode
// R23: as receiver capture each byte into the receive buffer
// R24: receive buffer full holds scl low until space frees
// R25: compare 7 or 10 bits per width control; ignore non-matching address
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "i2css_defines.svh"

module i2css_top import i2css_pkg::*; (
   input  wire logic        CLK_SYS,
   input  wire logic        NRST,
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [31:0] RDATA,
   input  wire logic        SCL_IN,
   output logic             SCL_OUT,
   output logic             SCL_OE_N,
   input  wire logic        SDA_IN,
   output logic             SDA_OUT,
   output logic             SDA_OE_N
);

   i2css_state_t st;
   i2css_state_t next_st;
   logic         scl_rise;
   logic         scl_fall;
   logic         bus_start;
   logic         bus_stop;
   logic         active;
   logic         addr_hit;
   logic         next_scl_oe_n;
   logic         next_sda_oe_n;

   // first address byte decode, 7-bit or 10-bit header
   function automatic logic first_hit(input logic [7:0] b, input i2css_cfg_t c,
                                      input logic [9:0] own, input logic h10);
      logic hdr;
      hdr = (b[7:3] == `I2CSS_HDR10) && (b[2:1] == own[9:8]);
      if (b[0] && c.ultra)
         first_hit = 1'b0;                                   // see R22
      else if (c.addr10)
         first_hit = hdr && (!b[0] || h10);                  // see R9 see R25
      else
         first_hit = (b[7:1] == own[6:0]);                   // see R25
   endfunction

   // edges seen on the synchronised lines only, so a stretched low phase
   // from any party simply delays the next edge
   assign scl_rise  = st.scl_s2 && !st.scl_q;                // see R3 see R6
   assign scl_fall  = !st.scl_s2 && st.scl_q;                // see R4 see R5
   assign bus_start = st.scl_s2 && st.scl_q && st.sda_q && !st.sda_s2;
   assign bus_stop  = st.scl_s2 && st.scl_q && !st.sda_q && st.sda_s2;
   assign active    = st.enable && !st.cfg.slave_off && !st.cfg.master_role;
   assign addr_hit  = first_hit(st.shreg, st.cfg, st.own_addr, st.hit10);

   always_comb begin
      next_st = st;
      next_st.rdata = 32'h0;

      // two-stage synchronisers, second stage feeds all the logic
      next_st.scl_s1 = SCL_IN;
      next_st.scl_s2 = st.scl_s1;
      next_st.scl_q  = st.scl_s2;
      next_st.sda_s1 = SDA_IN;
      next_st.sda_s2 = st.sda_s1;
      next_st.sda_q  = st.sda_s2;
      if (st.settle != `I2CSS_SETTLE_CYC)
         next_st.settle = st.settle + 3'h1;                  // see R13

      // register writes; config is frozen while enabled and kept while disabled
      if (WR) begin
         unique case (ADDR)
            `I2CSS_OFF_CONFIG: begin
               if (!st.enable) begin                         // see R11
                  next_st.cfg.master_role = WDATA[`I2CSS_CFG_MASTER_BIT];
                  next_st.cfg.addr10      = WDATA[`I2CSS_CFG_ADDR10_BIT];   // see R9
                  next_st.cfg.slave_off   = WDATA[`I2CSS_CFG_SLVOFF_BIT];   // see R10
                  next_st.cfg.ultra       = WDATA[`I2CSS_CFG_ULTRA_BIT];
               end
            end
            `I2CSS_OFF_OWN_ADDR: begin
               if (!st.enable)
                  next_st.own_addr = WDATA[9:0];             // see R8
            end
            `I2CSS_OFF_ENABLE: begin
               next_st.enable = WDATA[0];
            end
            `I2CSS_OFF_DATA_CMD: begin
               // command bit set means a master read command, not slave data
               if (st.enable && !WDATA[`I2CSS_CMD_BIT] && !st.flush_lock && !st.tx_full) begin // see R19 see R18
                  next_st.tx_full = 1'b1;
                  next_st.tx_data = WDATA[7:0];
               end
            end
            `I2CSS_OFF_EVENT_MASK: begin
               next_st.mask.rd_req = WDATA[`I2CSS_RAW_RDREQ_BIT];
               next_st.mask.abort  = WDATA[`I2CSS_RAW_ABORT_BIT];
            end
            default: begin
            end
         endcase
      end

      // register reads, data in the following cycle only
      if (RD) begin
         unique case (ADDR)
            `I2CSS_OFF_CONFIG: begin
               next_st.rdata[`I2CSS_CFG_MASTER_BIT] = st.cfg.master_role;
               next_st.rdata[`I2CSS_CFG_ADDR10_BIT] = st.cfg.addr10;
               next_st.rdata[`I2CSS_CFG_SLVOFF_BIT] = st.cfg.slave_off;
               next_st.rdata[`I2CSS_CFG_ULTRA_BIT]  = st.cfg.ultra;
            end
            `I2CSS_OFF_OWN_ADDR: begin
               next_st.rdata[9:0] = st.own_addr;
            end
            `I2CSS_OFF_ENABLE: begin
               next_st.rdata[0] = st.enable;
            end
            `I2CSS_OFF_DATA_CMD: begin
               next_st.rdata[7:0] = st.rx_data;
               next_st.rx_full    = 1'b0;
            end
            `I2CSS_OFF_RAW_STATUS: begin
               next_st.rdata[`I2CSS_RAW_RXFULL_BIT] = st.rx_full;
               next_st.rdata[`I2CSS_RAW_RDREQ_BIT]  = st.raw.rd_req;
               next_st.rdata[`I2CSS_RAW_ABORT_BIT]  = st.raw.abort;
               // a masked flag read as one counts as cleared
               if (!st.mask.rd_req)
                  next_st.raw.rd_req = 1'b0;                 // see R20
               if (!st.mask.abort)
                  next_st.raw.abort = 1'b0;                  // see R20
            end
            `I2CSS_OFF_EVENT_MASK: begin
               next_st.rdata[`I2CSS_RAW_RDREQ_BIT] = st.mask.rd_req;
               next_st.rdata[`I2CSS_RAW_ABORT_BIT] = st.mask.abort;
            end
            `I2CSS_OFF_CLR_RD_REQ: begin
               next_st.rdata[0]   = st.raw.rd_req;
               next_st.raw.rd_req = 1'b0;                    // see R20
            end
            `I2CSS_OFF_ABORT_CLEAR: begin
               next_st.rdata[0]     = st.raw.abort;
               next_st.raw.abort    = 1'b0;                  // see R20
               next_st.flush_lock   = 1'b0;                  // see R18
            end
            `I2CSS_OFF_STATUS: begin
               next_st.rdata[`I2CSS_ST_TXFULL_BIT]  = st.tx_full;
               next_st.rdata[`I2CSS_ST_RXFULL_BIT]  = st.rx_full;
               next_st.rdata[`I2CSS_ST_ACTIVE_BIT]  = (st.fsm != S_IDLE);
               next_st.rdata[`I2CSS_ST_STRETCH_BIT] = st.scl_drv;
               next_st.rdata[`I2CSS_ST_SETTLED_BIT] = (st.settle == `I2CSS_SETTLE_CYC);
            end
            default: begin
            end
         endcase
      end

      // bus side; event sets come after the clears above so a set wins
      if (!active) begin
         // buffers held empty while disabled; releasing both lines avoids a hung bus
         next_st.fsm     = S_IDLE;
         next_st.scl_drv = 1'b0;
         next_st.sda_drv = 1'b0;
         next_st.hit10   = 1'b0;
         if (!st.enable) begin
            next_st.tx_full = 1'b0;
            next_st.rx_full = 1'b0;
         end
      end else if (bus_start) begin
         // a repeated start keeps the 10-bit match for a following read
         next_st.fsm     = S_ADDR;
         next_st.cnt     = 4'h0;
         next_st.scl_drv = 1'b0;
         next_st.sda_drv = 1'b0;
      end else if (bus_stop) begin
         next_st.fsm     = S_IDLE;
         next_st.scl_drv = 1'b0;
         next_st.sda_drv = 1'b0;
         next_st.hit10   = 1'b0;
      end else begin
         unique case (st.fsm)
            S_IDLE: begin
            end
            S_ADDR, S_ADDR2, S_RX_BIT: begin
               if (scl_rise) begin
                  next_st.shreg = {st.shreg[6:0], st.sda_s2};  // see R2
                  next_st.cnt   = st.cnt + 4'h1;
               end else if (scl_fall && st.cnt == 4'h8) begin
                  next_st.cnt = 4'h0;
                  if (st.fsm == S_ADDR) begin
                     if (addr_hit) begin
                        next_st.sda_drv = 1'b1;              // see R14
                        next_st.rw      = st.shreg[0];       // see R14
                        if (!st.shreg[0])
                           next_st.hit10 = 1'b0;
                        next_st.fsm = S_ADDR_ACK;
                     end else begin
                        next_st.fsm = S_IDLE;                // see R25
                     end
                  end else if (st.fsm == S_ADDR2) begin
                     if (st.shreg == st.own_addr[7:0]) begin // see R25
                        next_st.sda_drv = 1'b1;
                        next_st.hit10   = 1'b1;
                        next_st.fsm     = S_ADDR_ACK;
                     end else begin
                        next_st.fsm = S_IDLE;
                     end
                  end else if (st.rx_full) begin
                     next_st.scl_drv = 1'b1;                 // see R24
                     next_st.fsm     = S_RX_STALL;
                  end else begin
                     next_st.rx_data = st.shreg;             // see R23
                     next_st.rx_full = 1'b1;
                     next_st.sda_drv = 1'b1;
                     next_st.fsm     = S_RX_ACK;
                  end
               end
            end
            S_ADDR_ACK: begin
               if (scl_fall) begin
                  next_st.sda_drv = 1'b0;
                  next_st.cnt     = 4'h0;
                  if (st.rw) begin
                     next_st.raw.rd_req = 1'b1;              // see R15
                     next_st.scl_drv    = 1'b1;              // see R15 see R6 see R1
                     if (st.tx_full) begin
                        // leftovers belong to an earlier transfer, never send them
                        next_st.raw.abort  = 1'b1;           // see R17
                        next_st.tx_full    = 1'b0;           // see R17
                        next_st.flush_lock = 1'b1;           // see R18
                     end
                     next_st.fsm = S_RD_WAIT;
                  end else if (st.cfg.addr10 && !st.hit10) begin
                     next_st.fsm = S_ADDR2;
                  end else begin
                     next_st.fsm = S_RX_BIT;
                  end
               end
            end
            S_RD_WAIT: begin
               if (st.tx_full && !st.flush_lock) begin
                  next_st.shreg   = st.tx_data;              // see R21
                  next_st.tx_full = 1'b0;
                  next_st.sda_drv = !st.tx_data[7];
                  next_st.scl_drv = 1'b0;                    // see R21
                  next_st.cnt     = 4'h0;
                  next_st.fsm     = S_TX_BIT;
               end
            end
            S_TX_BIT: begin
               if (scl_rise) begin
                  next_st.cnt = st.cnt + 4'h1;
               end else if (scl_fall) begin
                  if (st.cnt == 4'h8) begin
                     next_st.sda_drv = 1'b0;
                     next_st.fsm     = S_TX_ACK;
                  end else begin
                     next_st.shreg   = {st.shreg[6:0], 1'b0};
                     next_st.sda_drv = !st.shreg[6];         // see R2
                  end
               end
            end
            S_TX_ACK: begin
               if (scl_rise) begin
                  next_st.ack_seen = !st.sda_s2;
               end else if (scl_fall) begin
                  if (st.ack_seen && st.tx_full) begin
                     next_st.shreg   = st.tx_data;
                     next_st.tx_full = 1'b0;
                     next_st.sda_drv = !st.tx_data[7];
                     next_st.cnt     = 4'h0;
                     next_st.fsm     = S_TX_BIT;
                  end else if (st.ack_seen) begin
                     next_st.raw.rd_req = 1'b1;              // see R15
                     next_st.scl_drv    = 1'b1;
                     next_st.fsm        = S_RD_WAIT;
                  end else begin
                     next_st.fsm = S_IDLE;
                  end
               end
            end
            S_RX_STALL: begin
               if (!st.rx_full) begin
                  next_st.rx_data = st.shreg;                // see R24
                  next_st.rx_full = 1'b1;
                  next_st.sda_drv = 1'b1;
                  next_st.scl_drv = 1'b0;
                  next_st.fsm     = S_RX_ACK;
               end
            end
            S_RX_ACK: begin
               if (scl_fall) begin
                  next_st.sda_drv = 1'b0;
                  next_st.cnt     = 4'h0;
                  next_st.fsm     = S_RX_BIT;
               end
            end
            default: begin
               next_st.fsm     = S_IDLE;
               next_st.scl_drv = 1'b0;
               next_st.sda_drv = 1'b0;
            end
         endcase
      end
   end

   // synchronisers reset to one: a release mid-transfer may fake a start
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         st                 <= '0;
         st.cfg.master_role <= `I2CSS_RST_MASTER;            // see R13
         st.cfg.slave_off   <= `I2CSS_RST_SLVOFF;            // see R13
         st.cfg.addr10      <= `I2CSS_RST_ADDR10;
         st.cfg.ultra       <= `I2CSS_RST_ULTRA;
         st.own_addr        <= `I2CSS_RST_OWN_ADDR;
         st.mask            <= `I2CSS_RST_MASK;
         st.fsm             <= S_IDLE;
         st.scl_s1          <= 1'b1;                         // see R12
         st.scl_s2          <= 1'b1;
         st.scl_q           <= 1'b1;
         st.sda_s1          <= 1'b1;
         st.sda_s2          <= 1'b1;
         st.sda_q           <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // open-drain pins: the data level is always low, the enable decides
   assign RDATA    = st.rdata;
   assign SCL_OUT  = 1'b0;
   assign SDA_OUT  = 1'b0;

   // pin enables have their own flops fed from the next state, so the
   // pads see a clean register edge with no gate and no extra cycle
   always_comb begin
      next_scl_oe_n = !next_st.scl_drv;                      // see R1
      next_sda_oe_n = !next_st.sda_drv;
   end

   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         SCL_OE_N <= 1'b1;
         SDA_OE_N <= 1'b1;
      end else begin
         SCL_OE_N <= next_scl_oe_n;
         SDA_OE_N <= next_sda_oe_n;
      end
   end

endmodule // i2css_top

// ### tb/i2css_checker.sv
// concurrent checks on the ports of the two-wire slave controller
`timescale 1ns/1ps
`include "i2css_defines.svh"

module i2css_checker (
   input wire logic        CLK_SYS,
   input wire logic        NRST,
   input wire logic [7:0]  ADDR,
   input wire logic [31:0] WDATA,
   input wire logic        WR,
   input wire logic        RD,
   input wire logic [31:0] RDATA,
   input wire logic        SCL_IN,
   input wire logic        SCL_OUT,
   input wire logic        SCL_OE_N,
   input wire logic        SDA_IN,
   input wire logic        SDA_OUT,
   input wire logic        SDA_OE_N
);
   logic       en;
   logic       next_en;
   logic [7:0] cfg;
   logic [7:0] next_cfg;
   logic [9:0] own;
   logic [9:0] next_own;
   logic [3:0] age;
   logic [3:0] next_age;
   logic       live;
   logic       acc;
   // shadow copies, config writes are dropped while enabled
   always_comb begin
      next_en = (WR && ADDR == `I2CSS_OFF_ENABLE) ? WDATA[0] : en;
      next_cfg = (WR && !en && ADDR == `I2CSS_OFF_CONFIG) ? (WDATA[7:0] & 8'hc9) : cfg;
      next_own = (WR && !en && ADDR == `I2CSS_OFF_OWN_ADDR) ? WDATA[9:0] : own;
      next_age = (age == 4'hf) ? age : age + 4'h1;
   end
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         {en, cfg, own, age} <= {1'b0, 8'h41, `I2CSS_RST_OWN_ADDR, 4'h0};
      end else begin
         {en, cfg, own, age} <= {next_en, next_cfg, next_own, next_age};
      end
   end
   assign live = en && !cfg[0] && !cfg[6];
   assign acc = WR | RD;

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);

   AST_OPEN_DRAIN: assert property (SCL_OUT == 1'b0 && SDA_OUT == 1'b0)
      else $error("bus pin driven high");
   AST_SDA_IN_LOW: assert property ($changed(SDA_OE_N) |-> !$past(SCL_IN))
      else $error("data line moved while clock high");
   AST_STRETCH_LOW: assert property ($fell(SCL_OE_N) |-> !$past(SCL_IN))
      else $error("clock pulled during high phase");
   AST_QUIET: assert property (!live && !$past(live) |-> SCL_OE_N && SDA_OE_N)
      else $error("bus touched while slave not active");
   AST_SETTLED: assert property (RD && ADDR == `I2CSS_OFF_STATUS && age >= 4'h7 |=> RDATA[4])
      else $error("synchronisers not settled");
   AST_OWN_HELD: assert property (RD && ADDR == `I2CSS_OFF_OWN_ADDR |=> RDATA == {22'h0, $past(own)})
      else $error("own address not retained");
   AST_CFG_HELD: assert property (RD && ADDR == `I2CSS_OFF_CONFIG |=> RDATA == {24'h0, $past(cfg)})
      else $error("config not retained");
   AST_STRETCH_END: assert property ($rose(SCL_OE_N) |-> $past(acc) || $past(acc, 2) || $past(acc, 3))
      else $error("stretch ended without register access");
endmodule // i2css_checker

bind i2css_top i2css_checker u_chk (.CLK_SYS(CLK_SYS), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
   .RD(RD), .RDATA(RDATA), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE_N(SCL_OE_N), .SDA_IN(SDA_IN),
   .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N));

// ### tb/i2css_master.sv
// remote bus master model, open drain, tolerant of clock stretching
`timescale 1ns/1ps

module i2css_master (
   input  wire logic clk,
   input  wire logic scl,
   input  wire logic sda,
   output logic      scl_low,
   output logic      sda_low
);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask
   // high time counts only once the line reads high, so a stretching slave wins
   task automatic rise();
      int k;
      scl_low <= 1'b0;
      @(posedge clk);
      for (k = 0; k < 3000 && scl !== 1'b1; k++) @(posedge clk);
   endtask
   task automatic bit_io(input logic b, output logic r);
      hold(2);
      sda_low <= ~b;
      hold(2);
      rise();
      hold(1);
      r = sda;
      hold(2);
      scl_low <= 1'b1;
   endtask
   task automatic start();
      if (scl_low === 1'b1) begin
         hold(4);
         sda_low <= 1'b0;
         hold(2);
         rise();
      end
      hold(4);
      sda_low <= 1'b1;
      hold(4);
      scl_low <= 1'b1;
   endtask
   task automatic stop();
      hold(4);
      sda_low <= 1'b1;
      hold(2);
      rise();
      hold(4);
      sda_low <= 1'b0;
      hold(4);
   endtask
   // nine bits msb first, the last one is the acknowledge slot
   task automatic xfer(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) bit_io(d[i], q[i]);
   endtask
endmodule // i2css_master

// ### tb/i2css_top_test.sv
// self-checking bench of the two-wire slave controller
`timescale 1ns/1ps
`include "i2css_defines.svh"

module i2css_top_test;
   logic        clk, nrst, wr, rd, rd_d, m_scl, m_sda;
   logic        scl_out, scl_oe_n, sda_out, sda_oe_n;
   logic [7:0]  addr, d;
   logic [31:0] wdata, rdata;
   logic [9:0]  own;
   logic [8:0]  q;
   logic [63:0] exp_q[$];
   wire logic   scl, sda;
   int          n_errors, comparisons;
   assign scl = scl_oe_n & ~m_scl;
   assign sda = sda_oe_n & ~m_sda;
   i2css_top uut (.CLK_SYS(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .SCL_IN(scl), .SCL_OUT(scl_out), .SCL_OE_N(scl_oe_n), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n));
   i2css_master m (.clk(clk), .scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda));
   initial clk = 1'b0;
   always #10 clk = ~clk;
   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      exp_q.push_back({mk, e});
   endtask
   task automatic chk_reg();
      logic [63:0] e;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : {32'hffffffff, 32'hx};
      comparisons++;
      if ((rdata & e[63:32]) !== (e[31:0] & e[63:32])) begin
         n_errors++;
         $display("MISMATCH %0t register read %h expected %h", $time, rdata, e[31:0]);
      end
   endtask
   task automatic chk_link(input logic [8:0] g, input logic [8:0] e);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %0t bus bits %h expected %h", $time, g, e);
      end
   endtask
   // read data stand only in the cycle after the strobe
   always @(posedge clk) rd_d <= rd;
   always @(negedge clk) begin
      if (rd_d === 1'b1) chk_reg();
   end
   task automatic wait_stretch();
      int k;
      for (k = 0; k < 2000 && scl_oe_n !== 1'b0; k++) @(posedge clk);
   endtask
   task automatic end_of_test();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      n_errors++;
      end_of_test();
   end
   initial begin
      void'($urandom(32'hf15f));
      {nrst, wr, rd, addr, wdata} = '0;
      n_errors = 0;
      comparisons = 0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (8) @(posedge clk);
      rreg(`I2CSS_OFF_CONFIG, 32'h41, 32'hff);
      rreg(`I2CSS_OFF_OWN_ADDR, 32'h55, 32'h3ff);
      rreg(`I2CSS_OFF_STATUS, 32'h10, 32'h1f);
      own = 10'($urandom);
      own[6] = ~own[5];
      d = 8'($urandom);
      wreg(`I2CSS_OFF_OWN_ADDR, {22'h0, own});
      wreg(`I2CSS_OFF_CONFIG, 32'h0);
      wreg(`I2CSS_OFF_ENABLE, 32'h1);
      wreg(`I2CSS_OFF_OWN_ADDR, 32'h3ff);
      rreg(`I2CSS_OFF_OWN_ADDR, {22'h0, own}, 32'h3ff);
      m.start();
      m.xfer({own[6:0], 2'b01}, q);
      chk_link(q, {own[6:0], 2'b00});
      m.xfer({d, 1'b1}, q);
      chk_link(q, {d, 1'b0});
      fork
         m.xfer({~d, 1'b1}, q);
         begin
            wait_stretch();
            rreg(`I2CSS_OFF_STATUS, 32'h0a, 32'h0a);
            rreg(`I2CSS_OFF_DATA_CMD, {24'h0, d}, 32'hff);
         end
      join
      chk_link(q, {~d, 1'b0});
      rreg(`I2CSS_OFF_DATA_CMD, {24'h0, ~d}, 32'hff);
      m.stop();
      m.start();
      m.xfer({own[6:0] ^ 7'h01, 2'b01}, q);
      chk_link(q, {own[6:0] ^ 7'h01, 2'b01});
      m.stop();
      // stale byte left in transmit holding before the read request
      wreg(`I2CSS_OFF_DATA_CMD, {24'h0, ~d});
      m.start();
      fork
         begin
            m.xfer({own[6:0], 2'b11}, q);
            chk_link(q, {own[6:0], 2'b10});
            m.xfer(9'h1ff, q);
            chk_link(q, {d, 1'b1});
         end
         begin
            wait_stretch();
            rreg(`I2CSS_OFF_STATUS, 32'h08, 32'h09);
            wreg(`I2CSS_OFF_DATA_CMD, 32'h05a);
            rreg(`I2CSS_OFF_RAW_STATUS, 32'h60, 32'h60);
            rreg(`I2CSS_OFF_CLR_RD_REQ, 32'h1, 32'h1);
            wreg(`I2CSS_OFF_EVENT_MASK, 32'h0);
            rreg(`I2CSS_OFF_RAW_STATUS, 32'h40, 32'h60);
            rreg(`I2CSS_OFF_RAW_STATUS, 32'h0, 32'h60);
            rreg(`I2CSS_OFF_ABORT_CLEAR, 32'h0, 32'h1);
            wreg(`I2CSS_OFF_DATA_CMD, 32'h1a5);
            wreg(`I2CSS_OFF_DATA_CMD, {24'h0, d});
         end
      join
      m.stop();
      wreg(`I2CSS_OFF_ENABLE, 32'h0);
      wreg(`I2CSS_OFF_CONFIG, 32'h80);
      rreg(`I2CSS_OFF_OWN_ADDR, {22'h0, own}, 32'h3ff);
      wreg(`I2CSS_OFF_ENABLE, 32'h1);
      m.start();
      m.xfer({own[6:0], 2'b11}, q);
      chk_link(q, {own[6:0], 2'b11});
      m.stop();
      wreg(`I2CSS_OFF_ENABLE, 32'h0);
      wreg(`I2CSS_OFF_CONFIG, 32'h08);
      rreg(`I2CSS_OFF_CONFIG, 32'h08, 32'hff);
      wreg(`I2CSS_OFF_ENABLE, 32'h1);
      m.start();
      m.xfer({5'h1e, own[9:8], 2'b01}, q);
      chk_link(q, {5'h1e, own[9:8], 2'b00});
      m.xfer({own[7:0], 1'b1}, q);
      chk_link(q, {own[7:0], 1'b0});
      m.xfer({d, 1'b1}, q);
      chk_link(q, {d, 1'b0});
      m.stop();
      rreg(`I2CSS_OFF_DATA_CMD, {24'h0, d}, 32'hff);
      repeat (2) @(posedge clk);
      end_of_test();
   end
endmodule // i2css_top_test
